// ---- design/tmh_mode_ctrl.sv ----
// 8-bit timer with mode register: interval/PWM, clock select, output gating
// Summary of operation
// R1: enable cleared stops and zeroes counter
// R2: enable set counts on selected clock
// R3: clock select decodes five divisions or neighbour
// R4: mode field selects interval or PWM
// R5: output level bit sets default level
// R6: output enable bit gates the pin
// R7: reset clears mode register to zero
// R8: software changes selects only while stopped
`timescale 1ns/1ps
module tmh_mode_ctrl (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic [15:0]         addr,
	input  wire logic [7:0]          wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic [7:0]               rdata,
	input  wire logic                neighbour_timer,
	output logic                     timer_out,
	output logic                     timer_out_oe,
	output logic                     match_pulse,
	output logic                     setting_bad
);
	tmh_pkg::tmh_mode_reg_t mode_r;
	logic [7:0]             count_r;
	logic [7:0]             cmp_r;
	logic                   level_r;
	logic                   tick;
	logic                   sel_bad;
	logic                   mode_bad;
	logic                   match;
	logic [7:0]             rdata_nxt;
	logic                   hit_mode;
	logic                   hit_count;
	logic                   hit_cmp;
	logic                   mode_wr;
	logic                   cmp_wr;
	logic                   run_en;
	logic                   is_interval;
	logic                   is_pwm;
	logic                   step;
	logic                   at_cmp;
	logic                   at_top;
	logic                   level_flip;
	logic                   level_set;
	logic                   level_clr;

	// address decode; an unmapped address hits nothing, so it reads zero
	assign hit_mode  = (addr == tmh_pkg::TIMER_H_MODE_ADDR);
	assign hit_count = (addr == tmh_pkg::COUNT_ADDR);
	assign hit_cmp   = (addr == tmh_pkg::CMP_ADDR);

	// the counter has no write path: a write to its address is dropped
	assign mode_wr = wr && hit_mode;
	assign cmp_wr  = wr && hit_cmp;

	always_ff @(posedge core_clk) begin
		if (rst)
			mode_r <= tmh_pkg::tmh_mode_reg_t'(tmh_pkg::TIMER_H_MODE_RST); // see R7
		else if (mode_wr)
			mode_r <= tmh_pkg::tmh_mode_reg_t'(wdata);
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			cmp_r <= tmh_pkg::CMP_RST;
		else if (cmp_wr)
			cmp_r <= wdata;
	end

	// field views of the mode register
	assign run_en      = mode_r.timer_run_enable;
	assign is_interval = (mode_r.op_mode == tmh_pkg::TMH_MD_INTERVAL);
	assign is_pwm      = (mode_r.op_mode == tmh_pkg::TMH_MD_PWM);
	assign mode_bad    = !is_interval && !is_pwm; // see R4

	// selects are not shadowed; a change while running is the user's hazard (see R8)
	tmh_prescaler tmh_prescaler_i (
		.core_clk        (core_clk),
		.rst             (rst),
		.run             (run_en),
		.sel             (mode_r.count_clock_sel),
		.neighbour_timer (neighbour_timer),
		.tick            (tick),
		.sel_bad         (sel_bad)
	);

	// a prohibited mode freezes the counter instead of guessing a behaviour
	assign step   = tick && !mode_bad;
	assign at_cmp = (count_r == cmp_r);
	assign at_top = (count_r == 8'hff);
	assign match  = step && at_cmp;

	always_ff @(posedge core_clk) begin
		if (rst || !run_en)
			count_r <= 8'h00; // see R1
		else if (step) begin // see R2
			if (is_interval && at_cmp)
				count_r <= 8'h00;
			else
				count_r <= count_r + 8'h01;
		end
	end

	// interval toggles on match; pwm is active from zero up to compare
	assign level_flip = is_interval && match;
	assign level_set  = is_pwm && step && at_top;
	assign level_clr  = is_pwm && match && !at_top;

	always_ff @(posedge core_clk) begin
		if (rst || !run_en)
			level_r <= 1'b0;
		else if (level_flip)
			level_r <= !level_r;
		else if (level_set)
			level_r <= 1'b1;
		else if (level_clr)
			level_r <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			timer_out <= 1'b0;
		else
			timer_out <= mode_r.output_default_level ^ level_r; // see R5
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			timer_out_oe <= 1'b0;
		else
			timer_out_oe <= mode_r.output_pin_enable; // see R6
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			match_pulse <= 1'b0;
		else
			match_pulse <= match;
	end

	assign setting_bad = sel_bad || mode_bad;

	always_comb begin
		if (!rd)
			rdata_nxt = 8'h00;
		else if (hit_mode)
			rdata_nxt = mode_r;
		else if (hit_count)
			rdata_nxt = count_r;
		else if (hit_cmp)
			rdata_nxt = cmp_r;
		else
			rdata_nxt = 8'h00;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			rdata <= 8'h00;
		else
			rdata <= rdata_nxt;
	end
endmodule // tmh_mode_ctrl

// ---- design/tmh_pkg.sv ----
// package for the timer mode control block: register map, fields, constants
package tmh_pkg;
	localparam logic [15:0] TIMER_H_MODE_ADDR = 16'hff69;
	localparam logic [7:0]  TIMER_H_MODE_RST  = 8'h00;
	localparam logic [15:0] COUNT_ADDR        = 16'hff6a;
	localparam logic [15:0] CMP_ADDR          = 16'hff6b;
	localparam logic [7:0]  CMP_RST           = 8'hff;
	localparam int          PRESCALE_W        = 10;
	localparam int          CLK_PERIOD_NS     = 10;

	typedef enum logic [2:0] {
		TMH_CK_DIV1, TMH_CK_DIV2, TMH_CK_DIV4, TMH_CK_DIV64, TMH_CK_DIV1024, TMH_CK_NEIGH,
		TMH_CK_BAD6, TMH_CK_BAD7
	} tmh_clk_sel_t;

	typedef enum logic [1:0] {
		TMH_MD_INTERVAL = 2'b00, TMH_MD_BAD1 = 2'b01, TMH_MD_PWM = 2'b10, TMH_MD_BAD3 = 2'b11
	} tmh_mode_t;

	typedef struct packed {
		logic         timer_run_enable;
		tmh_clk_sel_t count_clock_sel;
		tmh_mode_t    op_mode;
		logic         output_default_level;
		logic         output_pin_enable;
	} tmh_mode_reg_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} tmh_bus_req_t;
endpackage : tmh_pkg

// ---- design/tmh_prescaler.sv ----
// prescaler producing one-cycle count ticks for the selected count clock
`timescale 1ns/1ps
module tmh_prescaler (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  run,
	input  tmh_pkg::tmh_clk_sel_t      sel,
	input  wire logic                  neighbour_timer,
	output logic                       tick,
	output logic                       sel_bad
);
	logic [tmh_pkg::PRESCALE_W-1:0] div_r;
	logic                           neigh_d_r;

	// prescaler free-runs from reset only while counting, so a start is aligned
	always_ff @(posedge core_clk) begin
		if (rst || !run)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			neigh_d_r <= 1'b0;
		else
			neigh_d_r <= neighbour_timer;
	end

	always_comb begin
		sel_bad = 1'b0;
		case (sel) // see R3
			tmh_pkg::TMH_CK_DIV1:    tick = run;
			tmh_pkg::TMH_CK_DIV2:    tick = run && (div_r[0] == 1'b1);
			tmh_pkg::TMH_CK_DIV4:    tick = run && (div_r[1:0] == 2'h3);
			tmh_pkg::TMH_CK_DIV64:   tick = run && (div_r[5:0] == 6'h3f);
			tmh_pkg::TMH_CK_DIV1024: tick = run && (div_r == 10'h3ff);
			tmh_pkg::TMH_CK_NEIGH:   tick = run && neighbour_timer && !neigh_d_r;
			default: begin
				// prohibited codes count nothing
				tick    = 1'b0;
				sel_bad = 1'b1;
			end
		endcase
	end
endmodule // tmh_prescaler

// ---- tb/tmh_mode_ctrl_asserts.sv ----
// port checker for the timer mode control block
`timescale 1ns/1ps
module tmh_mode_ctrl_asserts (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	input wire logic        timer_out,
	input wire logic        timer_out_oe,
	input wire logic        setting_bad
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence mwr; wr && addr == tmh_pkg::TIMER_H_MODE_ADDR; endsequence
	sequence crd; rd && addr == tmh_pkg::COUNT_ADDR; endsequence
	AST_STOP: assert property (mwr ##0 !wdata[7] ##2 crd |=> rdata == 8'h00)
		else $error("count kept");
	AST_RUN: assert property (mwr ##0 wdata[7:2] == 6'h20 ##2 crd ##2 crd
		|=> rdata == $past(rdata, 2) + 8'h02) else $error("count rate");
	AST_BAD_CLK: assert property (mwr ##0 wdata[6:4] > 3'h5 |=> setting_bad)
		else $error("clock code");
	AST_BAD_MODE: assert property (mwr ##0 wdata[2] |=> setting_bad)
		else $error("mode code");
	AST_GOOD: assert property (mwr ##0 wdata[6:4] <= 3'h5 && !wdata[2] |=> !setting_bad)
		else $error("false alarm");
	AST_OE: assert property (mwr |-> ##2 timer_out_oe == $past(wdata[0], 2))
		else $error("pin gate");
	AST_LEVEL: assert property (mwr ##0 !wdata[7] ##1 !wr [*2]
		|=> timer_out == $past(wdata[1], 3)) else $error("idle level");
	AST_RST: assert property (disable iff (1'b0) rst |=> rdata == 8'h00 && !timer_out_oe)
		else $error("reset state");
endmodule // tmh_mode_ctrl_asserts

bind tmh_mode_ctrl tmh_mode_ctrl_asserts tmh_mode_ctrl_asserts_i (
	.core_clk     (core_clk),
	.rst          (rst),
	.addr         (addr),
	.wdata        (wdata),
	.wr           (wr),
	.rd           (rd),
	.rdata        (rdata),
	.timer_out    (timer_out),
	.timer_out_oe (timer_out_oe),
	.setting_bad  (setting_bad)
);

// ---- tb/tmh_mode_ctrl_tb.sv ----
// self-checking bench for the timer mode control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
	$display("FAIL %0t mismatch", $time); end end
module tmh_mode_ctrl_tb;
	logic        core_clk = 0, rst = 1, wr = 0, rd = 0, neighbour_timer = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00, rdata, d, c;
	logic        timer_out, timer_out_oe, match_pulse, setting_bad;
	int          num_errors = 0, checks = 0, cyc = 0;
	logic [7:0]  md [7] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'h88};
	int          n [7] = '{1, 2, 4, 64, 1024, 2, 1};
	localparam logic [15:0] A = tmh_pkg::TIMER_H_MODE_ADDR;
	localparam logic [15:0] C = tmh_pkg::COUNT_ADDR;
	tmh_mode_ctrl tmh_mode_ctrl_i (
		.core_clk        (core_clk),
		.rst             (rst),
		.addr            (addr),
		.wdata           (wdata),
		.wr              (wr),
		.rd              (rd),
		.rdata           (rdata),
		.neighbour_timer (neighbour_timer),
		.timer_out       (timer_out),
		.timer_out_oe    (timer_out_oe),
		.match_pulse     (match_pulse),
		.setting_bad     (setting_bad)
	);
	initial forever #(tmh_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	// free-running neighbour output: a rising edge every second cycle
	always @(posedge core_clk) neighbour_timer <= ~neighbour_timer;
	always @(posedge core_clk) if (++cyc == 5000) begin
		num_errors++;
		test_done;
	end
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
		@(posedge core_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		@(posedge core_clk);
		wr <= 0;
		rd <= 0;
		#1 d = rdata;
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		bus(0, A, 8'h00);
		`CHK(d, tmh_pkg::TIMER_H_MODE_RST)
		for (int i = 0; i < 7; i++) begin
			bus(1, A, 8'h00);
			bus(0, C, 8'h00);
			`CHK(d, 8'h00)
			bus(1, A, md[i]);
			bus(0, C, 8'h00);
			c = d;
			// reads spaced by two count periods
			repeat (2 * n[i] - 2) @(posedge core_clk);
			bus(0, C, 8'h00);
			`CHK(d - c, 8'h02)
			$display("row %0d done", i);
		end
		bus(1, A, 8'h00);
		bus(1, A, 8'h70);
		`CHK(setting_bad, 1'b1)
		bus(1, A, 8'h0C);
		`CHK(setting_bad, 1'b1)
		bus(1, A, 8'h03);
		`CHK(setting_bad, 1'b0)
		repeat (2) @(posedge core_clk);
		#1 `CHK(timer_out_oe, 1'b1)
		`CHK(timer_out, 1'b1)
		@(posedge core_clk);
		rst <= 1;
		repeat (2) @(posedge core_clk);
		rst <= 0;
		bus(0, A, 8'h00);
		`CHK(d, 8'h00)
		`CHK(timer_out_oe, 1'b0)
		`CHK(timer_out, 1'b0)
		bus(0, 16'h0000, 8'h00);
		`CHK(d, 8'h00)
		// compare of 2 at full rate: a match every third cycle
		bus(1, tmh_pkg::CMP_ADDR, 8'h02);
		bus(1, A, 8'h80);
		repeat (3) @(posedge core_clk);
		#1 `CHK(match_pulse, 1'b1)
		@(posedge core_clk);
		#1 `CHK(match_pulse, 1'b0)
		`CHK(timer_out, 1'b1)
		repeat (2) @(posedge core_clk);
		#1 `CHK(match_pulse, 1'b1)
		bus(0, tmh_pkg::CMP_ADDR, 8'h00);
		`CHK(d, 8'h02)
		$display("awkward cases done");
		test_done;
	end
endmodule // tmh_mode_ctrl_tb
